//--- adaptive_illumination_gain.sv
// per-frame adaptive gain and led current control with apb registers
`timescale 1ns/100ps
// Overview of operation
// - analyse each frame, derive three gains
// - multiply every channel pixel by its gain
// - gain chosen so few pixels clip
// - issue red, green, blue led currents
// - gain and led power chosen jointly
// - gain times current keeps white point
// - power extreme keeps brightness, lowers power
// - power never below unchanged-brightness point
// - bright extreme keeps power, raises brightness
// - blend setting picks point between extremes
// - settings steer gain and led power
// - below bright extreme, power falls as channel content dims
// - white content nominal, black minimum at power extreme
module adaptive_illumination_gain (
   input wire logic pclk,                  // clock 100 MHz
   input wire logic presetn,               // async reset, low
   input wire logic psel,                  // apb select
   input wire logic penable,               // apb enable
   input wire logic pwrite,                // apb direction
   input wire logic [7:0] paddr,           // apb byte address
   input wire logic [31:0] pwdata,         // apb write data
   output logic [31:0] prdata,             // apb read data
   output logic pready,                    // apb ready
   output logic pslverr,                   // apb error
   input wire logic pix_valid,             // input pixel valid
   output logic pix_ready,                 // input can accept
   input wire logic [23:0] pix_data,       // r[23:16] g[15:8] b[7:0]
   input wire logic pix_eof,               // last pixel of frame
   output logic out_valid,                 // output pixel valid
   input wire logic out_ready,             // downstream accept
   output logic [23:0] out_data,           // gained pixel
   output logic [29:0] led_current         // r[29:20] g[19:10] b[9:0]
);
   // ----------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------
   logic enable;
   logic [7:0] blend;
   logic [illum_pkg::HIST_W-1:0] clip_allow;
   logic [illum_pkg::CUR_W-1:0] cur_nom, cur_min;
   logic [illum_pkg::GAIN_W-1:0] gain [3];    // applied gains
   logic [illum_pkg::CUR_W-1:0] cur [3];      // applied currents
   logic [illum_pkg::HIST_W-1:0] top_cnt [3];
   logic [illum_pkg::PIX_W-1:0] thr [3];
   logic [15:0] frames;
   logic f_valid, f_ready, f_eof;
   logic [23:0] f_data;
   logic in_take;
   logic [31:0] rdmux;
   logic acc;

   // gain = full / peak, 2.8 fixed point, saturated
   function automatic logic [illum_pkg::GAIN_W-1:0] calc_gain(
      input logic [illum_pkg::PIX_W-1:0] pk);
      logic [17:0] q;
      q = 18'h0;
      if (pk == '0) begin
         calc_gain = illum_pkg::GAIN_ONE;
      end else begin
         q = {2'h0, illum_pkg::PIX_FULL, 8'h00} / {10'h000, pk};
         calc_gain = (q > 18'(illum_pkg::GAIN_MAX)) ?
            illum_pkg::GAIN_MAX : q[illum_pkg::GAIN_W-1:0];
      end
   endfunction

   // pixel times gain with saturation
   function automatic logic [illum_pkg::PIX_W-1:0] apply_gain(
      input logic [illum_pkg::PIX_W-1:0] p,
      input logic [illum_pkg::GAIN_W-1:0] g);
      logic [17:0] m;
      m = {10'h000, p} * {8'h00, g};
      if (m[17:illum_pkg::GAIN_FRAC] > 10'(illum_pkg::PIX_FULL)) begin
         apply_gain = illum_pkg::PIX_FULL;
      end else begin
         apply_gain = m[15:illum_pkg::GAIN_FRAC];
      end
   endfunction

   // current: power-save point is nom*peak/full, blended toward nom
   function automatic logic [illum_pkg::CUR_W-1:0] calc_cur(
      input logic [illum_pkg::PIX_W-1:0] pk,
      input logic [illum_pkg::CUR_W-1:0] nom,
      input logic [illum_pkg::CUR_W-1:0] mn,
      input logic [7:0] bl);
      logic [17:0] save;
      logic [17:0] mix;
      save = ({8'h00, nom} * {10'h000, pk}) / 18'(illum_pkg::PIX_FULL);
      if (save < {8'h00, mn}) begin
         save = {8'h00, mn};
      end
      // weights sum to full scale so both blend ends are exact
      mix = (save * {10'h000, ~bl} + {8'h00, nom} * {10'h000, bl}) /
         18'(illum_pkg::PIX_FULL);
      calc_cur = mix[illum_pkg::CUR_W-1:0];
   endfunction

   // ----------------------------------------------------------------
   // apb slave, zero wait
   // ----------------------------------------------------------------
   assign acc = psel && penable && pready;

   // writable settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable <= 1'b0;
         blend <= illum_pkg::BLEND_RST;
         clip_allow <= illum_pkg::CLIP_RST;
         cur_nom <= illum_pkg::CUR_NOM_RST;
         cur_min <= illum_pkg::CUR_MIN_RST;
      end else if (acc && pwrite) begin
         unique case (paddr)
            illum_pkg::OFF_CTRL: enable <= pwdata[0];
            illum_pkg::OFF_BLEND: blend <= pwdata[7:0];
            illum_pkg::OFF_CLIP: clip_allow <= pwdata[19:0];
            illum_pkg::OFF_CURNOM: cur_nom <= pwdata[9:0];
            illum_pkg::OFF_CURMIN: cur_min <= pwdata[9:0];
            default: ;
         endcase
      end
   end

   // read multiplexer
   always_comb begin
      rdmux = 32'h0;
      unique case (paddr)
         illum_pkg::OFF_CTRL: rdmux = {31'h0, enable};
         illum_pkg::OFF_BLEND: rdmux = {24'h0, blend};
         illum_pkg::OFF_CLIP: rdmux = {12'h0, clip_allow};
         illum_pkg::OFF_CURNOM: rdmux = {22'h0, cur_nom};
         illum_pkg::OFF_CURMIN: rdmux = {22'h0, cur_min};
         illum_pkg::OFF_GAIN_RG: rdmux = {6'h0, gain[0], 6'h0, gain[1]};
         illum_pkg::OFF_GAIN_B: rdmux = {22'h0, gain[2]};
         illum_pkg::OFF_CUR_RG: rdmux = {6'h0, cur[0], 6'h0, cur[1]};
         illum_pkg::OFF_CUR_B: rdmux = {22'h0, cur[2]};
         illum_pkg::OFF_FRAMES: rdmux = {16'h0, frames};
         default: rdmux = 32'h0;
      endcase
   end

   // read data, error on unmapped or misaligned address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
         prdata <= rdmux;
         pslverr <= psel && !penable &&
            (paddr > illum_pkg::OFF_FRAMES || paddr[1:0] != 2'h0);
      end
   end

   // ----------------------------------------------------------------
   // input fifo
   // ----------------------------------------------------------------
   pix_fifo #(.WIDTH(illum_pkg::FIFO_W + 1), .DEPTH(illum_pkg::FIFO_D))
   u_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .in_valid(pix_valid),
      .in_ready(pix_ready),
      .in_data({pix_eof, pix_data}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data({f_eof, f_data})
   );
   assign f_ready = !out_valid || out_ready; // output stall backs up fifo
   assign in_take = f_valid && f_ready;

   // ----------------------------------------------------------------
   // per channel frame analysis
   // ----------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < 3; c++) begin : g_ch
         logic [illum_pkg::PIX_W-1:0] px;
         logic [illum_pkg::PIX_W-1:0] lvl;
         logic [illum_pkg::HIST_W-1:0] next_cnt;
         assign px = f_data[23-8*c -: 8];
         // clip level with this pixel: the first clip_allow pixels above
         // it may clip, after that it follows the running maximum
         always_comb begin
            lvl = thr[c];
            next_cnt = top_cnt[c];
            if (px > thr[c]) begin
               if (top_cnt[c] >= clip_allow) begin
                  lvl = px;
               end else begin
                  next_cnt = top_cnt[c] + 1'b1;
               end
            end
         end
         // level and clip budget per frame, cleared after last pixel
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               thr[c] <= '0;
               top_cnt[c] <= '0;
            end else if (in_take) begin
               if (f_eof) begin
                  thr[c] <= '0;
                  top_cnt[c] <= '0;
               end else begin
                  thr[c] <= lvl;
                  top_cnt[c] <= next_cnt;
               end
            end
         end
         // joint gain and current update at frame end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               gain[c] <= illum_pkg::GAIN_ONE;
               cur[c] <= illum_pkg::CUR_NOM_RST;
            end else if (in_take && f_eof) begin
               if (!enable) begin
                  gain[c] <= illum_pkg::GAIN_ONE;
                  cur[c] <= cur_nom;
               end else begin
                  // gain and current from same peak
                  gain[c] <= calc_gain(lvl);
                  // scaled power keeps brightness
                  // blend keeps power
                  cur[c] <= calc_cur(lvl, cur_nom, cur_min, blend);
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // pixel path and led command outputs
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_data <= 24'h0;
      end else if (f_ready) begin
         out_valid <= f_valid;
         if (in_take) begin
            out_data <= {apply_gain(f_data[23:16], gain[0]),
                         apply_gain(f_data[15:8], gain[1]),
                         apply_gain(f_data[7:0], gain[2])};
         end
      end
   end

   // led commands register one cycle after the currents
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         led_current <= {3{illum_pkg::CUR_NOM_RST}};
         frames <= 16'h0;
      end else begin
         led_current <= {cur[0], cur[1], cur[2]};
         if (in_take && f_eof) begin
            frames <= frames + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_gain_frame;
      @(posedge pclk) disable iff (!presetn)
      !(in_take && f_eof) |=> $stable(gain[0]);
   endproperty
   a_gain_frame: assert property (p_gain_frame)
      else $error("gain changed off frame boundary");
   property p_cur_follow;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> led_current[29:20] == $past(cur[0]);
   endproperty
   a_cur_follow: assert property (p_cur_follow)
      else $error("led command lags current");
   property p_sat;
      @(posedge pclk) disable iff (!presetn)
      (in_take && f_data[23:16] == illum_pkg::PIX_FULL &&
       gain[0] >= illum_pkg::GAIN_ONE)
      |=> out_data[23:16] == illum_pkg::PIX_FULL;
   endproperty
   a_sat: assert property (p_sat)
      else $error("full scale pixel not saturated");
   property p_cur_bound;
      @(posedge pclk) disable iff (!presetn)
      enable |-> cur[1] <= cur_nom || $past(in_take && f_eof) == 1'b0;
   endproperty
   a_cur_bound: assert property (p_cur_bound)
      else $error("led current above nominal");
   property p_gain_min;
      @(posedge pclk) disable iff (!presetn)
      gain[2] >= illum_pkg::GAIN_ONE;
   endproperty
   a_gain_min: assert property (p_gain_min)
      else $error("gain below unity");
   property p_apb;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready;
   endproperty
   a_apb: assert property (p_apb)
      else $error("apb not ready after setup");
   c_frame: cover property (@(posedge pclk) in_take && f_eof);
   c_full: cover property (@(posedge pclk) !pix_ready);
   c_gain: cover property (@(posedge pclk) gain[0] > illum_pkg::GAIN_ONE);
endmodule

//--- adaptive_illumination_gain_tb.sv
// self-checking bench for the adaptive illumination gain block
`timescale 1ns/100ps
module adaptive_illumination_gain_tb;
   localparam int TIMEOUT = 20000;
   localparam logic [31:0] RST_TAB [10] = '{32'h0, 32'h0, 32'h40, 32'h3FF,
      32'h10, 32'h01000100, 32'h100, 32'h03FF03FF, 32'h3FF, 32'h0};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pix_valid = 1'b0;
   logic pix_ready;
   logic [23:0] pix_data = 24'h0;
   logic pix_eof = 1'b0;
   logic out_valid;
   logic out_ready = 1'b0;
   logic [23:0] out_data;
   logic [29:0] led_current;
   logic [9:0] drive_r;
   logic [9:0] drive_g;
   logic [9:0] drive_b;
   logic [31:0] rd;
   logic er;
   logic [24:0] exp_q[$];
   int err_total = 0;
   int num_checks = 0;
   int seed = 40797;
   int cycles = 0;
   int orm = 0;
   int n = 0;
   int en = 0;
   int blend = 0;
   int gain[3] = '{256, 256, 256};
   int cur[3] = '{1023, 1023, 1023};
   int mx[3] = '{0, 0, 0};
   int used[3] = '{0, 0, 0};
   int clip = 64;

   // ---------------------------------
   // design, partner and clock
   // ---------------------------------
   adaptive_illumination_gain adaptive_illumination_gain_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pix_valid(pix_valid), .pix_ready(pix_ready),
      .pix_data(pix_data), .pix_eof(pix_eof), .out_valid(out_valid),
      .out_ready(out_ready), .out_data(out_data),
      .led_current(led_current));
   led_drv_model led_drv_model_i (.pclk(pclk), .presetn(presetn),
      .led_current(led_current), .drive_r(drive_r), .drive_g(drive_g),
      .drive_b(drive_b));
   always #5 pclk = ~pclk;

   // ---------------------------------
   // checking and reference model
   // ---------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   function automatic int sat(input int p, input int g);
      int v;
      v = (p * g) >> 8;
      return (v > 255) ? 255 : v;
   endfunction

   // expected pixel from current gains; eof moves the frame's settings in
   task automatic pop(input logic [24:0] e);
      logic [23:0] x;
      int p;
      x = 24'h0;
      for (int c = 0; c < 3; c++) begin
         p = int'(e[c*8 +: 8]);
         x[c*8 +: 8] = 8'(sat(p, gain[c]));
         // first clip pixels above the level may clip, then it follows
         if (p > mx[c] && used[c] >= clip) begin
            mx[c] = p;
         end else if (p > mx[c]) begin
            used[c]++;
         end
      end
      check({8'h00, out_data}, {8'h00, x});
      if (e[24]) begin
         for (int c = 0; c < 3; c++) begin
            gain[c] = (en == 0) ? 256 : (mx[c] == 0) ? 256 :
               ((65280 / mx[c]) > 1023 ? 1023 : 65280 / mx[c]);
            cur[c] = (en == 0 || blend == 255) ? 1023 :
               ((1023 * mx[c] / 255) < 16 ? 16 : 1023 * mx[c] / 255);
            mx[c] = 0;
            used[c] = 0;
         end
      end
   endtask

   // output monitor and downstream stall pattern
   always @(posedge pclk) begin
      cycles++;
      if (cycles == TIMEOUT) begin
         err_total++;
         stop_test();
      end
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         if (exp_q.size() == 0) check(32'h1, 32'h0);
         else pop(exp_q.pop_front());
      end
      out_ready <= (orm == 2) ? 1'($random(seed)) : (orm == 1);
   end

   // ---------------------------------
   // bus and pixel drivers
   // ---------------------------------
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic send(input logic [23:0] p, input logic eof);
      pix_valid <= 1'b1;
      pix_data <= p;
      pix_eof <= eof;
      do @(posedge pclk); while (pix_ready !== 1'b1);
      exp_q.push_back({eof, p});
   endtask

   task automatic frame(input logic [23:0] p, input int k);
      for (int i = 0; i < k; i++) send(i == k - 1 ? 24'($random(seed)) & p
         : p, i == k - 1);
      pix_valid <= 1'b0;
   endtask

   // waits for the output side to empty, then checks leds and gains
   task automatic settle(input string name);
      logic [29:0] c;
      for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge pclk);
      repeat (4) @(posedge pclk);
      check(exp_q.size(), 0);
      c = {10'(cur[2]), 10'(cur[1]), 10'(cur[0])};
      check({2'b00, led_current}, {2'b00, c});
      check({2'b00, drive_r, drive_g, drive_b}, {2'b00, c});
      apb(1'b0, 8'h14, 32'h0);
      check(rd, {6'h00, 10'(gain[2]), 6'h00, 10'(gain[1])});
      apb(1'b0, 8'h18, 32'h0);
      check(rd, {22'h000000, 10'(gain[0])});
      $display("done: %s", name);
   endtask

   // ---------------------------------
   // main sequence
   // ---------------------------------
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         check(rd, RST_TAB[i]);
      end
      apb(1'b1, 8'h14, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      check(rd, 32'h01000100);
      apb(1'b1, 8'h28, 32'hFFFFFFFF);
      check({31'h0, er}, 32'h1);
      apb(1'b0, 8'h02, 32'h0);
      check({rd[30:0], er}, 32'h1);
      $display("done: registers");
      // fill the fifo with the output stalled until it refuses
      pix_valid <= 1'b1;
      pix_data <= 24'($random(seed));
      for (int i = 0; i < 24; i++) begin
         @(posedge pclk);
         if (pix_ready === 1'b1) begin
            exp_q.push_back({pix_eof, pix_data});
            n++;
            pix_data <= 24'($random(seed));
         end
      end
      pix_valid <= 1'b0;
      check(32'(n >= 16 && n <= 17), 32'h1);
      orm = 2;
      @(posedge pclk);
      send(24'($random(seed)), 1'b1);
      pix_valid <= 1'b0;
      settle("bypass");
      apb(1'b1, 8'h08, 32'h2);
      clip = 2;
      apb(1'b1, 8'h00, 32'h1);
      en = 1;
      frame(24'hFFFFFF, 8);
      settle("white");
      frame(24'h000000, 8);
      settle("black");
      for (int i = 0; i < 12; i++) send(24'($random(seed)), i == 11);
      pix_valid <= 1'b0;
      settle("random");
      apb(1'b1, 8'h04, 32'hFF);
      apb(1'b0, 8'h04, 32'h0);
      check(rd, 32'hFF);
      blend = 255;
      frame(24'h000000, 6);
      settle("bright");
      stop_test();
   end
endmodule

//--- illum_pkg.sv
// constants for the adaptive illumination gain block
package illum_pkg;
   localparam int PIX_W = 8;                  // bits per colour sample
   localparam int GAIN_W = 10;                // gain, 2.8 fixed point
   localparam int GAIN_FRAC = 8;              // fraction bits of gain
   localparam int CUR_W = 10;                 // led current command width
   localparam int HIST_W = 20;                // clip counter width
   localparam int FIFO_W = 3 * PIX_W;         // one rgb pixel
   localparam int FIFO_D = 16;                // fifo depth
   localparam logic [GAIN_W-1:0] GAIN_ONE = 10'h100;
   localparam logic [GAIN_W-1:0] GAIN_MAX = 10'h3FF;
   localparam logic [PIX_W-1:0] PIX_FULL = 8'hFF;
   localparam logic [CUR_W-1:0] CUR_NOM_RST = 10'h3FF;
   localparam logic [CUR_W-1:0] CUR_MIN_RST = 10'h010;
   localparam logic [HIST_W-1:0] CLIP_RST = 20'h00040;
   localparam logic [7:0] BLEND_RST = 8'h00;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;   // bit0 enable
   localparam logic [7:0] OFF_BLEND = 8'h04;  // 0 power save .. FF bright
   localparam logic [7:0] OFF_CLIP = 8'h08;   // allowed clipped pixels
   localparam logic [7:0] OFF_CURNOM = 8'h0C; // nominal led current
   localparam logic [7:0] OFF_CURMIN = 8'h10; // minimum led current
   localparam logic [7:0] OFF_GAIN_RG = 8'h14;// applied gains red, green
   localparam logic [7:0] OFF_GAIN_B = 8'h18; // applied gain blue
   localparam logic [7:0] OFF_CUR_RG = 8'h1C; // applied currents r, g
   localparam logic [7:0] OFF_CUR_B = 8'h20;  // applied current b
   localparam logic [7:0] OFF_FRAMES = 8'h24; // frame counter
endpackage

//--- led_drv_model.sv
// led driver model: latches the red, green and blue current commands
`timescale 1ns/100ps
module led_drv_model (
   input wire logic pclk,               // clock
   input wire logic presetn,            // async reset, low
   input wire logic [29:0] led_current, // r, g, b commands
   output logic [9:0] drive_r,          // applied red current
   output logic [9:0] drive_g,          // applied green current
   output logic [9:0] drive_b           // applied blue current
);
   // ---------------------------------
   // current latch
   // ---------------------------------
   // the driver follows each command one cycle later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_r <= 10'h3FF;
         drive_g <= 10'h3FF;
         drive_b <= 10'h3FF;
      end else begin
         drive_r <= led_current[29:20];
         drive_g <= led_current[19:10];
         drive_b <= led_current[9:0];
      end
   end
endmodule

//--- pix_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module pix_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input wire logic clk,               // clock
   input wire logic rst_n,             // async reset, low
   input wire logic in_valid,          // write request
   output logic in_ready,              // not full
   input wire logic [WIDTH-1:0] in_data, // write data
   output logic out_valid,             // not empty
   input wire logic out_ready,         // read accept
   output logic [WIDTH-1:0] out_data   // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp, rp;
   logic [AW:0] cnt;
   logic [AW:0] next_cnt;
   logic wr, rd;
   assign out_valid = (cnt != '0);
   assign out_data = mem[rp];
   assign wr = in_valid && in_ready;
   assign rd = out_valid && out_ready;
   // storage write
   always_ff @(posedge clk) begin
      if (wr) begin
         mem[wp] <= in_data;
      end
   end
   // fill count after this cycle's write and read
   always_comb begin
      next_cnt = cnt;
      if (wr && !rd) begin
         next_cnt = cnt + 1'b1;
      end else if (rd && !wr) begin
         next_cnt = cnt - 1'b1;
      end
   end

   // pointers, fill count and registered not-full flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
         in_ready <= 1'b1;
      end else begin
         if (wr) begin
            wp <= wp + 1'b1;
         end
         if (rd) begin
            rp <= rp + 1'b1;
         end
         cnt <= next_cnt;
         in_ready <= (next_cnt != (AW+1)'(DEPTH));
      end
   end
endmodule
